//--- src/dual_serial_pkg.sv
// Shared constants and types of the dual SPI / I2C register port
`default_nettype none
package dual_serial_pkg;
  // SPI frame geometry
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int RW_BIT = 23;
  localparam int ADDR_MSB = 22;
  localparam int ADDR_LSB = 16;
  localparam logic [7:0] READBACK_PAD = 8'h00;
  // Pin levels at rest: strap, data, clock line, sdi, sclk, frame select
  localparam logic [5:0] PIN_IDLE = 6'h39;
  // I2C addressing
  localparam logic [3:0] ADDR_UPPER = 4'h9;
  localparam logic [2:0] STRAP_VDD = 3'h0;
  localparam logic [2:0] STRAP_GND = 3'h1;
  localparam logic [2:0] STRAP_SCL = 3'h2;
  localparam logic [2:0] STRAP_SDA = 3'h3;
  localparam logic [6:0] BROADCAST_ADDR = 7'h47;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Software reset through the shared trigger register
  localparam logic [6:0] TRIGGER_REG_ADDR = 7'h20;
  localparam int RESET_FIELD_LSB = 0;
  localparam logic [3:0] RESET_CODE = 4'ha;
  // I2C target states
  typedef enum logic [6:0] {
    I_IDLE = 7'h01,
    I_ADDR = 7'h02,
    I_AACK = 7'h04,
    I_RX = 7'h08,
    I_RACK = 7'h10,
    I_TX = 7'h20,
    I_TACK = 7'h40
  } i2c_state_t;
endpackage : dual_serial_pkg
`default_nettype wire

//--- src/pin_sync.sv
// Two-stage synchronisers with edge detection, one per pin
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Raw pins and synchronised views
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      logic prev_q;
      // Edge detect looks only at the second and third stage, never the first
      always_ff @(posedge clk_in)
      begin
        // Reset to the idle level so that release of reset makes no false edge
        if (!resetn_in)
        begin
          meta_q <= IDLE_LEVEL[i];
          sync_q <= IDLE_LEVEL[i];
          prev_q <= IDLE_LEVEL[i];
        end
        else if (ce_in)
        begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign level_out[i] = sync_q;
      assign rise_out[i] = sync_q & ~prev_q;
      assign fall_out[i] = ~sync_q & prev_q;
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

//--- src/dual_serial_register_port.sv
// SPI and I2C target front end that turns serial frames into register accesses
//
// Notes on behaviour
// - Frame select low opens an SPI access; its return high ends it.
// - Serial input sampled on falling serial-clock edges; clock may be gated.
// - Frames are 24 bits; fewer falling edges before release discard the access.
// - Three-wire: only the first 24 bits count, extra edges ignored.
// - Frame select high: clock and data ignored, serial output released.
// - Frame is read flag, 7-bit address, then 16 data bits.
// - Serial output off after reset until readback enable is set.
// - Reads need readback enabled; data comes out in the following frame.
// - Readback launched on falling or rising edge per edge select.
// - Four-wire/daisy: exact multiples of 24 use last 24 bits, else discard.
// - Only 7-bit target addresses; ten-bit addressing never matches.
// - General call 0x00 then 0x06 resets at rising edge of that acknowledge.
// - Works at standard, fast and fast-plus rates with one protocol.
// - Each byte has a ninth clock: receiver pulls data low to acknowledge.
// - Address acknowledged only on match, low for whole ninth-clock high.
// - Stop releases the bus; wait for new start and matching address.
// - Every byte acknowledged; write commits at falling edge of lower-byte ack.
// - Address is 1001b plus three bits from how the strap pin is tied.
// - Strap pin sampled during the first byte and latched for the transaction.
// - Broadcast address answered for writes only, never for reads.
// - Read: address, command, repeated start read, upper byte, ack, lower byte.
// - Command byte is the register address.
// - Writing 1010b to the trigger reset field fires a software reset.
`default_nettype none
module dual_serial_register_port (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Interface configuration
  input wire logic readback_output_enable_in,
  input wire logic readback_edge_select_in,
  // SPI pins
  input wire logic spi_frame_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  // I2C pins
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_out,
  input wire logic address_strap_pin_in,
  // Register side
  output logic [6:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [15:0] reg_rdata_in,
  output logic soft_reset_out
);
  logic [5:0] pin_raw;
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic frame_n;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi;
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic i2c_start;
  logic i2c_stop;
  logic strap;

  // Every pin crosses two flip-flops before use
  assign pin_raw = {address_strap_pin_in, i2c_sda_in, i2c_scl_in,
                    spi_sdi_in, spi_sclk_in, spi_frame_n_in};
  pin_sync #(.WIDTH(6), .IDLE_LEVEL(dual_serial_pkg::PIN_IDLE)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .async_in(pin_raw),
    .level_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // Clock edges are blocked while frame select is high; data is only used on those edges
  assign frame_n = pin_lvl[0];
  assign frame_start = pin_fall[0];
  assign frame_end = pin_rise[0];
  assign sclk_fall = pin_fall[1] & ~frame_n;
  assign sclk_rise = pin_rise[1] & ~frame_n;
  assign sdi = pin_lvl[2];
  assign scl = pin_lvl[3];
  assign scl_rise = pin_rise[3];
  assign scl_fall = pin_fall[3];
  assign sda = pin_lvl[4];
  assign strap = pin_lvl[5];
  // Start and stop: data edge while clock is high
  assign i2c_start = pin_fall[4] & scl;
  assign i2c_stop = pin_rise[4] & scl;

  // ---------------- SPI ----------------
  logic [23:0] spi_sr_q;
  logic [4:0] spi_cnt_q;
  logic spi_full_q;
  logic spi_pend_q;
  logic spi_sdo_q;
  logic four_wire;
  logic spi_valid;
  logic spi_wr;
  logic spi_rd;
  logic [15:0] rdata_q;

  assign four_wire = readback_output_enable_in;
  // Whole frames only; three-wire never shifts past 24 so cnt stays zero
  assign spi_valid = frame_end & spi_full_q & (spi_cnt_q == 5'h00);
  assign spi_wr = spi_valid & ~spi_sr_q[dual_serial_pkg::RW_BIT];
  assign spi_rd = spi_valid & spi_sr_q[dual_serial_pkg::RW_BIT] & four_wire;

  // Shift register: daisy data passes through, readback is preloaded
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      spi_sr_q <= 24'h000000;
      spi_cnt_q <= 5'h00;
      spi_full_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (frame_start)
      begin
        spi_cnt_q <= 5'h00;
        spi_full_q <= 1'b0;
        spi_sr_q <= spi_pend_q ? {dual_serial_pkg::READBACK_PAD, rdata_q} : 24'h000000;
      end
      else if (sclk_fall && (four_wire || !spi_full_q))
      begin
        spi_sr_q <= {spi_sr_q[22:0], sdi};
        if (spi_cnt_q == dual_serial_pkg::FRAME_LAST)
        begin
          spi_cnt_q <= 5'h00;
          spi_full_q <= 1'b1;
        end
        else
        begin
          spi_cnt_q <= spi_cnt_q + 5'h01;
        end
      end
    end
  end

  // Read pending between the command frame and the data frame
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      spi_pend_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (spi_rd)
      begin
        spi_pend_q <= 1'b1;
      end
      else if (frame_start)
      begin
        spi_pend_q <= 1'b0;
      end
    end
  end

  // Output bit launched on the selected edge
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      spi_sdo_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (frame_start)
      begin
        // First readback bit must stand before any falling-edge launch
        spi_sdo_q <= spi_pend_q & dual_serial_pkg::READBACK_PAD[7];
      end
      else if (readback_edge_select_in && sclk_rise)
      begin
        spi_sdo_q <= spi_sr_q[23];
      end
      else if (!readback_edge_select_in && sclk_fall)
      begin
        spi_sdo_q <= spi_sr_q[22];
      end
    end
  end

  assign spi_sdo_out = spi_sdo_q;
  assign spi_sdo_oe_out = four_wire & ~frame_n;

  // ---------------- I2C ----------------
  dual_serial_pkg::i2c_state_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [1:0] byte_q;
  logic gc_q;
  logic rw_q;
  logic tx_lower_q;
  logic sda_oe_q;
  logic [6:0] cmd_q;
  logic [7:0] upper_q;
  logic [15:0] i2c_wdata_q;
  logic i2c_wr_q;
  logic i2c_rd_q;
  logic gc_fire_q;
  logic seen_hi_q;
  logic seen_lo_q;
  logic diff_scl_q;
  logic [2:0] strap_code;
  logic [6:0] own_addr;
  logic [6:0] rx_addr;
  logic own_hit;
  logic acc_hit;

  // Strap tied to supply, ground, clock or data, judged over the first byte
  always_comb
  begin
    if (!seen_lo_q)
      strap_code = dual_serial_pkg::STRAP_VDD;
    else if (!seen_hi_q)
      strap_code = dual_serial_pkg::STRAP_GND;
    else if (!diff_scl_q)
      strap_code = dual_serial_pkg::STRAP_SCL;
    else
      strap_code = dual_serial_pkg::STRAP_SDA;
  end

  // Ten-bit prefixes never equal the fixed 1001b upper bits
  assign own_addr = {dual_serial_pkg::ADDR_UPPER, strap_code};
  assign rx_addr = sh_q[7:1];
  assign own_hit = (rx_addr == own_addr);
  assign acc_hit = own_hit || (!sh_q[0] && (rx_addr == dual_serial_pkg::BROADCAST_ADDR ||
                   rx_addr == dual_serial_pkg::GENERAL_CALL_ADDR));

  // Strap observation while the address byte is on the bus; the flags then
  // freeze, which latches the strap code for the rest of the transaction
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      seen_hi_q <= 1'b0;
      seen_lo_q <= 1'b0;
      diff_scl_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (i2c_start)
      begin
        seen_hi_q <= 1'b0;
        seen_lo_q <= 1'b0;
        diff_scl_q <= 1'b0;
      end
      else if (st_q == dual_serial_pkg::I_ADDR)
      begin
        seen_hi_q <= seen_hi_q | strap;
        seen_lo_q <= seen_lo_q | ~strap;
        diff_scl_q <= diff_scl_q | (strap ^ scl);
      end
    end
  end

  // Target byte engine: sample on clock rise, drive on clock fall
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_q <= dual_serial_pkg::I_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      byte_q <= 2'h0;
      gc_q <= 1'b0;
      rw_q <= 1'b0;
      tx_lower_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cmd_q <= 7'h00;
      upper_q <= 8'h00;
      i2c_wdata_q <= 16'h0000;
      i2c_wr_q <= 1'b0;
      i2c_rd_q <= 1'b0;
      gc_fire_q <= 1'b0;
    end
    else if (ce_in)
    begin
      i2c_wr_q <= 1'b0;
      i2c_rd_q <= 1'b0;
      gc_fire_q <= 1'b0;
      if (i2c_stop)
      begin
        st_q <= dual_serial_pkg::I_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (i2c_start)
      begin
        st_q <= dual_serial_pkg::I_ADDR;
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        unique case (st_q)
          dual_serial_pkg::I_IDLE:
          begin
            sda_oe_q <= 1'b0;
          end
          dual_serial_pkg::I_ADDR, dual_serial_pkg::I_RX:
          begin
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda};
              bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall && bit_q == dual_serial_pkg::BYTE_BITS)
            begin
              bit_q <= 4'h0;
              if (st_q == dual_serial_pkg::I_RX)
              begin
                sda_oe_q <= 1'b1;
                st_q <= dual_serial_pkg::I_RACK;
              end
              else if (acc_hit)
              begin
                sda_oe_q <= 1'b1;
                st_q <= dual_serial_pkg::I_AACK;
                rw_q <= sh_q[0];
                gc_q <= (rx_addr == dual_serial_pkg::GENERAL_CALL_ADDR);
                i2c_rd_q <= sh_q[0];
              end
              else
              begin
                st_q <= dual_serial_pkg::I_IDLE;
              end
            end
          end
          dual_serial_pkg::I_AACK:
          begin
            if (scl_fall)
            begin
              bit_q <= 4'h0;
              if (rw_q)
              begin
                st_q <= dual_serial_pkg::I_TX;
                tx_q <= rdata_q[15:8];
                sda_oe_q <= ~rdata_q[15];
                tx_lower_q <= 1'b0;
              end
              else
              begin
                st_q <= dual_serial_pkg::I_RX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          dual_serial_pkg::I_RACK:
          begin
            if (scl_rise && gc_q && byte_q == 2'h0 && sh_q == dual_serial_pkg::GC_RESET_BYTE)
            begin
              gc_fire_q <= 1'b1;
            end
            else if (scl_fall)
            begin
              sda_oe_q <= 1'b0;
              st_q <= dual_serial_pkg::I_RX;
              if (byte_q != 2'h3)
                byte_q <= byte_q + 2'h1;
              unique case (byte_q)
                2'h0: cmd_q <= sh_q[6:0];
                2'h1: upper_q <= sh_q;
                2'h2:
                begin
                  i2c_wdata_q <= {upper_q, sh_q};
                  i2c_wr_q <= ~gc_q;
                end
                2'h3: ;
              endcase
            end
          end
          dual_serial_pkg::I_TX:
          begin
            if (scl_rise)
            begin
              bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bit_q == dual_serial_pkg::BYTE_BITS)
              begin
                sda_oe_q <= 1'b0;
                st_q <= dual_serial_pkg::I_TACK;
              end
              else
              begin
                sda_oe_q <= ~tx_q[6];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
          end
          dual_serial_pkg::I_TACK:
          begin
            if (scl_rise && (sda || tx_lower_q))
            begin
              st_q <= dual_serial_pkg::I_IDLE;
            end
            else if (scl_fall)
            begin
              st_q <= dual_serial_pkg::I_TX;
              bit_q <= 4'h0;
              tx_q <= rdata_q[7:0];
              sda_oe_q <= ~rdata_q[7];
              tx_lower_q <= 1'b1;
            end
          end
          default:
          begin
            st_q <= dual_serial_pkg::I_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe_out = sda_oe_q;

  // ---------------- Register side ----------------
  logic [6:0] addr_q;
  logic [15:0] wdata_q;
  logic wr_q;
  logic rd_q;
  logic soft_reset_q;

  // SPI wins a same-cycle clash; links run far slower than clk so it is rare
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      addr_q <= 7'h00;
      wdata_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (ce_in)
    begin
      wr_q <= spi_wr | (i2c_wr_q & ~spi_valid);
      rd_q <= spi_rd | (i2c_rd_q & ~spi_valid);
      if (spi_valid)
      begin
        addr_q <= spi_sr_q[dual_serial_pkg::ADDR_MSB:dual_serial_pkg::ADDR_LSB];
        wdata_q <= spi_sr_q[15:0];
      end
      else if (i2c_wr_q || i2c_rd_q)
      begin
        addr_q <= cmd_q;
        wdata_q <= i2c_wdata_q;
      end
    end
  end

  // Read data sampled in the read strobe cycle, shared by both links
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rdata_q <= 16'h0000;
    else if (ce_in && rd_q)
      rdata_q <= reg_rdata_in;
  end

  // Software reset from general call or the trigger register code
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      soft_reset_q <= 1'b0;
    else if (ce_in)
      soft_reset_q <= gc_fire_q | (wr_q && addr_q == dual_serial_pkg::TRIGGER_REG_ADDR &&
        wdata_q[dual_serial_pkg::RESET_FIELD_LSB +: 4] == dual_serial_pkg::RESET_CODE);
  end

  assign reg_addr_out = addr_q;
  assign reg_wdata_out = wdata_q;
  assign reg_wr_out = wr_q;
  assign reg_rd_out = rd_q;
  assign soft_reset_out = soft_reset_q;
endmodule : dual_serial_register_port
`default_nettype wire

//--- test/dual_serial_register_port_assertions.sv
// Concurrent checks on the pins and register strobes of the serial port
`default_nettype none
module dual_serial_register_port_assertions (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // SPI side
  input wire logic readback_output_enable_in,
  input wire logic spi_frame_n_in,
  input wire logic spi_sdo_oe_out,
  // I2C side
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  input wire logic i2c_sda_out,
  input wire logic i2c_sda_oe_out,
  // Register side
  input wire logic [6:0] reg_addr_out,
  input wire logic [15:0] reg_wdata_out,
  input wire logic reg_wr_out,
  input wire logic reg_rd_out,
  input wire logic soft_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Five cycles cover the pin synchroniser before the output must let go
  sdo_hiz_a: assert property (spi_frame_n_in [*5] |-> !spi_sdo_oe_out)
    else $error("readback output driven while frame idle");
  sdo_off_a: assert property (!readback_output_enable_in |-> !spi_sdo_oe_out)
    else $error("readback output driven in three-wire mode");
  sdo_on_a: assert property ((readback_output_enable_in && !spi_frame_n_in) [*5]
    |-> spi_sdo_oe_out)
    else $error("readback output not driven inside frame");
  wr_pulse_a: assert property ($rose(reg_wr_out) |=> !reg_wr_out)
    else $error("write strobe longer than one cycle");
  rd_wr_excl_a: assert property (reg_rd_out |-> !reg_wr_out)
    else $error("read and write strobes together");
  // Data line may only move while the clock line is low, else it fakes start or stop
  sda_change_a: assert property ($changed(i2c_sda_oe_out) |-> !i2c_scl_in)
    else $error("data line moved while clock high");
  sda_low_a: assert property (i2c_sda_oe_out |-> i2c_sda_out == 1'b0)
    else $error("data line driven high");
  ack_hold_a: assert property ($rose(i2c_scl_in) && i2c_sda_oe_out |-> i2c_sda_oe_out [*4])
    else $error("acknowledge dropped during clock high");
  trig_reset_a: assert property (reg_wr_out
    && reg_addr_out == dual_serial_pkg::TRIGGER_REG_ADDR
    && reg_wdata_out[3:0] == dual_serial_pkg::RESET_CODE |=> soft_reset_out)
    else $error("trigger write gave no soft reset");
  reset_pulse_a: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset longer than one cycle");
  stop_release_a: assert property (i2c_scl_in && $rose(i2c_sda_in)
    |-> ##3 !i2c_sda_oe_out [*4])
    else $error("data line held after stop");
  // Main scenarios reached
  wr_c: cover property (reg_wr_out);
  rd_c: cover property (reg_rd_out);
  rst_c: cover property (soft_reset_out);
  ack_c: cover property ($rose(i2c_sda_oe_out));
endmodule : dual_serial_register_port_assertions
bind dual_serial_register_port dual_serial_register_port_assertions chk_u (
  .clk_in(clk_in), .resetn_in(resetn_in), .readback_output_enable_in(readback_output_enable_in),
  .spi_frame_n_in(spi_frame_n_in), .spi_sdo_oe_out(spi_sdo_oe_out), .i2c_scl_in(i2c_scl_in),
  .i2c_sda_in(i2c_sda_in), .i2c_sda_out(i2c_sda_out), .i2c_sda_oe_out(i2c_sda_oe_out),
  .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out), .reg_wr_out(reg_wr_out),
  .reg_rd_out(reg_rd_out), .soft_reset_out(soft_reset_out));
`default_nettype wire

//--- test/serial_host_model.sv
// SPI host and I2C controller model on the far side of the port
`default_nettype none
module serial_host_model (
  // Clock
  input wire logic clk_in,
  // SPI host pins
  output logic frame_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input wire logic sdo_in,
  // I2C controller pins
  output logic scl_out,
  output logic sda_drv_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus levels
  initial
  begin
    frame_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask : w
  // Phases of six clocks keep above the synchroniser minimum; clock parks low
  task automatic spi_xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    frame_n_out <= 1'b0;
    w(6);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_out <= tx[i];
      sclk_out <= 1'b1;
      w(5);
      @(negedge clk_in) rx = {rx[46:0], sdo_in};
      @(posedge clk_in) sclk_out <= 1'b0;
      w(6);
    end
    frame_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    w(12);
  endtask : spi_xfer
  // Start, or repeated start when the clock is low
  task automatic i2c_start;
    sda_drv_out <= 1'b1;
    w(5);
    scl_out <= 1'b1;
    w(5);
    sda_drv_out <= 1'b0;
    w(5);
    scl_out <= 1'b0;
    w(3);
  endtask : i2c_start
  task automatic i2c_stop;
    sda_drv_out <= 1'b0;
    w(5);
    scl_out <= 1'b1;
    w(5);
    sda_drv_out <= 1'b1;
    w(10);
  endtask : i2c_stop
  // Eight data bits then the ninth; data changes three clocks after clock falls
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv_out <= tx[i];
      w(5);
      scl_out <= 1'b1;
      w(5);
      @(negedge clk_in) rx[i] = sda_in;
      @(posedge clk_in) scl_out <= 1'b0;
      w(3);
    end
  endtask : i2c_byte
endmodule : serial_host_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the dual SPI / I2C register port
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rb_en = 1'b0;
  logic rb_edge = 1'b0;
  logic strap = 1'b1;
  logic [15:0] rdata = 16'hc35a;
  wire frame_n, sclk, sdi, scl, sda_drv, sdo, sdo_oe, sda_o, sda_oe, wr, rd, srst, sda_w, sdo_w;
  wire [6:0] addr;
  wire [15:0] wdata;
  logic [6:0] a_q;
  logic [15:0] d_q;
  logic [6:0] own = {dual_serial_pkg::ADDR_UPPER, dual_serial_pkg::STRAP_VDD};
  int n_fail = 0;
  int n_compared = 0;
  int wr_n = 0;
  int rd_n = 0;
  int rst_n = 0;
  always #10 clk = ~clk;
  // Open-drain data line with pull-up; readback floats when not driven
  assign sda_w = sda_drv & ~(sda_oe & ~sda_o);
  assign sdo_w = sdo_oe ? sdo : 1'bz;
  // Tally strobes and keep what the last access carried
  always @(posedge clk)
  begin
    if (wr) wr_n++;
    if (rd) rd_n++;
    if (srst) rst_n++;
    if (wr | rd) a_q <= addr;
    if (wr) d_q <= wdata;
  end
  dual_serial_register_port dut_u (.clk_in(clk), .resetn_in(resetn), .ce_in(1'b1),
    .readback_output_enable_in(rb_en), .readback_edge_select_in(rb_edge),
    .spi_frame_n_in(frame_n), .spi_sclk_in(sclk), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
    .spi_sdo_oe_out(sdo_oe), .i2c_scl_in(scl), .i2c_sda_in(sda_w), .i2c_sda_out(sda_o),
    .i2c_sda_oe_out(sda_oe), .address_strap_pin_in(strap), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata),
    .soft_reset_out(srst));
  serial_host_model host_u (.clk_in(clk), .frame_n_out(frame_n), .sclk_out(sclk),
    .sdi_out(sdi), .sdo_in(sdo_w), .scl_out(scl), .sda_drv_out(sda_drv), .sda_in(sda_w));
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // One I2C byte written by the controller, acknowledge bit checked
  task automatic wb(input logic [7:0] b, input logic ack);
    logic [8:0] rx;
    host_u.i2c_byte({b, 1'b1}, rx);
    `CHK("ack bit", ack, rx[0])
  endtask : wb
  task automatic t_spi3;
    logic [47:0] rx;
    int w0;
    w0 = wr_n;
    host_u.spi_xfer(48'h26_beef, 24, rx);
    `CHK("write count", w0 + 1, wr_n)
    `CHK("write addr", 7'h26, a_q)
    `CHK("write data", 16'hbeef, d_q)
    host_u.spi_xfer(48'h02_8888, 23, rx);
    `CHK("short frame", w0 + 1, wr_n)
    host_u.spi_xfer({24'h07_2222, 6'h3f}, 30, rx);
    `CHK("long data", 16'h2222, d_q)
    `CHK("long count", w0 + 2, wr_n)
    $display("three-wire frames done");
  endtask : t_spi3
  task automatic t_spi4;
    logic [47:0] rx;
    int w0;
    int r0;
    @(posedge clk) rb_en <= 1'b1;
    w0 = wr_n;
    host_u.spi_xfer({24'h26_0000, 24'h05_5a5a}, 48, rx);
    `CHK("chain addr", 7'h05, a_q)
    `CHK("chain data", 16'h5a5a, d_q)
    host_u.spi_xfer(48'h09_0001, 25, rx);
    `CHK("odd count", w0 + 1, wr_n)
    for (int e = 0; e < 2; e++)
    begin
      @(posedge clk) rb_edge <= e[0];
      r0 = rd_n;
      host_u.spi_xfer(48'h8a_0000, 24, rx);
      host_u.spi_xfer(48'h8a_0000, 24, rx);
      `CHK("read count", r0 + 2, rd_n)
      `CHK("read addr", 7'h0a, a_q)
      `CHK("readback", {dual_serial_pkg::READBACK_PAD, rdata}, rx[23:0])
    end
    @(posedge clk) rb_en <= 1'b0;
    $display("four-wire frames done");
  endtask : t_spi4
  task automatic t_i2c_wr;
    int w0;
    w0 = wr_n;
    host_u.i2c_start();
    wb({dual_serial_pkg::ADDR_UPPER, dual_serial_pkg::STRAP_GND, 1'b0}, 1'b1);
    host_u.i2c_stop();
    host_u.i2c_start();
    wb({own, 1'b0}, 1'b0);
    wb(8'h26, 1'b0);
    wb(8'h12, 1'b0);
    wb(8'h34, 1'b0);
    host_u.i2c_stop();
    `CHK("i2c count", w0 + 1, wr_n)
    `CHK("i2c addr", 7'h26, a_q)
    `CHK("i2c data", 16'h1234, d_q)
    host_u.i2c_start();
    wb({dual_serial_pkg::BROADCAST_ADDR, 1'b0}, 1'b0);
    wb(8'h2b, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h01, 1'b0);
    host_u.i2c_stop();
    `CHK("broadcast data", 16'h0001, d_q)
    $display("i2c writes done");
  endtask : t_i2c_wr
  task automatic t_i2c_rd;
    logic [8:0] hi;
    logic [8:0] lo;
    int r0;
    r0 = rd_n;
    host_u.i2c_start();
    wb({own, 1'b0}, 1'b0);
    wb(8'h1f, 1'b0);
    host_u.i2c_start();
    wb({own, 1'b1}, 1'b0);
    host_u.i2c_byte({8'hff, 1'b0}, hi);
    host_u.i2c_byte(9'h1ff, lo);
    host_u.i2c_stop();
    `CHK("i2c read", rdata, {hi[8:1], lo[8:1]})
    `CHK("read reg", 7'h1f, a_q)
    host_u.i2c_start();
    wb({dual_serial_pkg::BROADCAST_ADDR, 1'b1}, 1'b1);
    host_u.i2c_stop();
    `CHK("read strobes", r0 + 1, rd_n)
    $display("i2c reads done");
  endtask : t_i2c_rd
  task automatic t_reset;
    logic [47:0] rx;
    int s0;
    s0 = rst_n;
    host_u.i2c_start();
    wb({dual_serial_pkg::GENERAL_CALL_ADDR, 1'b0}, 1'b0);
    wb(dual_serial_pkg::GC_RESET_BYTE, 1'b0);
    host_u.i2c_stop();
    `CHK("general call", s0 + 1, rst_n)
    host_u.spi_xfer(48'h20_000a, 24, rx);
    `CHK("trigger reset", s0 + 2, rst_n)
    $display("soft resets done");
  endtask : t_reset
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_spi3();
    t_spi4();
    t_i2c_wr();
    t_i2c_rd();
    t_reset();
    print_verdict();
  end
  // A hang counts as a mismatch
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("timeout");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
